// *** src/pcse_cfg.svh ***
// Constants for the coordinator sleep entry block.
// Assumes inclusion before the package and the design modules.
`ifndef PCSE_CFG_SVH
`define PCSE_CFG_SVH

// ************************************************************
// Sleep control register layout
// ************************************************************
`define PCSE_SLEEP_CAL_FIELD_LSB      0
`define PCSE_SLEEP_CAL_FIELD_W        4
`define PCSE_SLEEP_CAL_FIELD_READ     4'h1
`define PCSE_SLEEP_CAL_FIELD_WRITE    4'h0
`define PCSE_SLEEP_ENABLE_BIT_BIT       4
`define PCSE_WAKEPIN_BIT     5
`define PCSE_MEDWAKE_BIT     6
`define PCSE_DELAY_LSB       8
`define PCSE_DELAY_W         4
`define PCSE_SLEEP_RST       16'h0000

// ************************************************************
// Transmit opportunity timing
// ************************************************************
`define PCSE_TO_DEFAULT      8'h20
`define PCSE_TO_MIN          8'h1d
`define PCSE_TO_UNIT_NS      100
`define PCSE_CLK_NS          25
`define PCSE_TO_UNIT_CYC ((`PCSE_TO_UNIT_NS + `PCSE_CLK_NS - 1) / `PCSE_CLK_NS)
`define PCSE_DELAY_UNIT_CYC  16'h0100
`define PCSE_MAX_NODES       8'h08
`define PCSE_NODE_RST        8'hff
`define PCSE_NOISE_CYC       4'h3
`define PCSE_COORD_ID        8'h00

`endif

// *** src/pcse_pkg.sv ***
// Types shared by the coordinator sleep entry block.
// Assumes pcse_cfg.svh supplies the numeric constants.
`default_nettype none
package pcse_pkg;
    // Decoded view of the sleep control register.
    typedef struct packed {
        logic [3:0] delay;
        logic       med_wake;
        logic       pin_wake;
        logic       sleep_en;
        logic [3:0] cal;
    } pcse_sleep_s;

    // PLCA configuration seen by the cycle engine.
    typedef struct packed {
        logic       plca_en;
        logic [7:0] node;
        logic [7:0] node_count;
        logic [7:0] to_timer;
    } pcse_plca_s;

    typedef enum logic [1:0] {
        ST_AWAKE  = 2'b00,
        ST_DELAY  = 2'b01,
        ST_SLEEP  = 2'b10
    } pcse_pwr_e;
endpackage
`default_nettype wire

// *** src/pcse_cycle.sv ***
// Transmit opportunity timer and bus cycle counter.
// Assumes synchronous inputs on one clock and an asynchronous low reset.
`include "pcse_cfg.svh"
`default_nettype none
module pcse_cycle (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        crs,
    input  wire logic [7:0]  to_timer,
    input  wire logic [7:0]  node_count,
    output logic             cycle_start,
    output logic [7:0]       cur_opp
);
    logic [7:0] opp_ff;
    logic [7:0] cnt_ff;
    logic [1:0] sub_ff;
    logic       tick;
    logic       opp_end;
    logic [7:0] last_opp;

    // Timer advances in 100 ns units; carrier freezes the opportunity.
    assign tick     = (sub_ff == 2'(`PCSE_TO_UNIT_CYC - 1));
    assign opp_end  = tick && !crs && (cnt_ff + 8'h01 >= to_timer);
    assign last_opp = (node_count == 8'h00) ? 8'h00 : node_count - 8'h01;
    assign cycle_start = run && opp_end && (opp_ff >= last_opp);
    assign cur_opp  = opp_ff;

    // Counters clear whenever the engine is stopped.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sub_ff <= 2'h0;
            cnt_ff <= 8'h00;
            opp_ff <= 8'h00;
        end
        else if (!run || crs)
        begin
            sub_ff <= 2'h0;
            cnt_ff <= 8'h00;
            if (!run) opp_ff <= 8'h00;
        end
        else
        begin
            sub_ff <= tick ? 2'h0 : sub_ff + 2'h1;
            cnt_ff <= opp_end ? 8'h00 : (tick ? cnt_ff + 8'h01 : cnt_ff);
            if (opp_end)
                opp_ff <= cycle_start ? 8'h00 : opp_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** src/pcse_top.sv ***
// Coordinator sleep entry control with PLCA beacon generation.
// Assumes the station controller drives the register strobes directly.
//
// Notes on behaviour
// - Reads of the sleep register return 0x0001 in the calibration field.
// - Node zero sends a beacon at the start of every bus cycle.
// - In sleep the transmitter and beacons run until analog supply fails.
// - Own beacons count as activity and wake an inactivity-sleeping node.
// - Noise filtering delays carrier sense, limiting the timer range.
// - Opportunity timer resets to 32, meaning 3.2 us.
`include "pcse_cfg.svh"
`default_nettype none
module pcse_top (
    input  wire logic               CORE_CLK,
    input  wire logic               RESET_N,
    input  wire logic               SLEEP_WR,
    input  wire logic [15:0]        SLEEP_WDATA,
    output pcse_pkg::pcse_sleep_s   SLEEP_RDATA,
    input  wire logic               PLCA_WR,
    input  wire logic               PLCA_EN_IN,
    input  wire logic [7:0]         NODE_IN,
    input  wire logic [7:0]         NODE_COUNT_IN,
    input  wire logic               TO_WR,
    input  wire logic [7:0]         TO_IN,
    output logic [7:0]              TO_OUT,
    output logic                    TO_BELOW_MIN,
    input  wire logic               INACT_SLEEP_EN,
    input  wire logic               INACT_TIMEOUT,
    input  wire logic               ANALOG_SUPPLY_OK,
    input  wire logic               WAKE_PIN,
    input  wire logic               RX_ACTIVITY,
    output logic                    BEACON,
    output logic                    TX_ENABLE,
    output logic                    CRS,
    output pcse_pkg::pcse_pwr_e     PWR_STATE
);
    import pcse_pkg::*;

    // ********************************************************
    // Registers
    // ********************************************************
    pcse_sleep_s sleep_ff;
    pcse_plca_s  plca_ff;
    pcse_pwr_e   pwr_ff;
    pcse_pwr_e   nxt_pwr;
    logic [15:0] dly_ff;
    logic [15:0] nxt_dly;
    logic [3:0]  flt_ff;
    logic        beacon_ff;
    logic        crs_ff;
    logic        cycle_start;
    logic [7:0]  cur_opp;
    logic        is_coord;
    logic        run;
    logic        wake_evt;
    logic        own_act;
    pcse_sleep_s wr_view;
    logic [3:0]  nxt_flt;
    logic        flt_full;
    logic        nxt_beacon;

    // Scale a delay code into clock cycles.
    function automatic logic [15:0] delay_cycles(input logic [3:0] code);
        delay_cycles = 16'(code) * `PCSE_DELAY_UNIT_CYC;
    endfunction

    // ********************************************************
    // Decoding
    // ********************************************************
    // Only the low eleven bits carry fields; the upper bits are ignored.
    assign wr_view  = pcse_sleep_s'(SLEEP_WDATA[10:0]);
    assign is_coord = (plca_ff.node == `PCSE_COORD_ID);
    // The engine keeps running in sleep while supply holds.
    assign run      = plca_ff.plca_en && ANALOG_SUPPLY_OK;
    // A beacon on the line is seen by our own receiver too.
    assign own_act  = beacon_ff;
    assign wake_evt = (sleep_ff.pin_wake && WAKE_PIN) ||
                      (sleep_ff.med_wake && (RX_ACTIVITY || own_act));

    // Register file; plain ports stand in for management access.
    // The calibration field is kept as written but drives no logic.
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sleep_ff <= pcse_sleep_s'(11'(`PCSE_SLEEP_RST));
            plca_ff  <= '{1'b0, `PCSE_NODE_RST, `PCSE_MAX_NODES,
                          `PCSE_TO_DEFAULT};
        end
        else
        begin
            if (SLEEP_WR)
                sleep_ff <= wr_view;
            else if (pwr_ff == ST_SLEEP && wake_evt)
                sleep_ff.sleep_en <= 1'b0;
            if (PLCA_WR)
            begin
                plca_ff.plca_en    <= PLCA_EN_IN;
                plca_ff.node       <= NODE_IN;
                plca_ff.node_count <= NODE_COUNT_IN;
            end
            if (TO_WR)
                plca_ff.to_timer <= TO_IN;
        end
    end

    // Calibration field always reads back as one.
    always_comb
    begin
        SLEEP_RDATA     = sleep_ff;
        SLEEP_RDATA.cal = `PCSE_SLEEP_CAL_FIELD_READ;
    end
    // The timer reads back as held; nothing clamps it to the safe floor.
    assign TO_OUT       = plca_ff.to_timer;
    // Flags a setting under the safe floor; the block still obeys it.
    assign TO_BELOW_MIN = (plca_ff.to_timer < `PCSE_TO_MIN);

    // ********************************************************
    // Power sequence
    // ********************************************************
    // Inactivity sleep may also enter; a coordinator then wakes itself.
    // The block does not refuse inactivity sleep on node zero: keeping a
    // coordinator out of it is left to the station controller.
    always_comb
    begin
        nxt_pwr = pwr_ff;
        nxt_dly = dly_ff;
        unique case (pwr_ff)
            ST_AWAKE:
            begin
                if ((SLEEP_WR && wr_view.sleep_en) ||
                    (INACT_SLEEP_EN && INACT_TIMEOUT))
                begin
                    nxt_pwr = ST_DELAY;
                    nxt_dly = delay_cycles(SLEEP_WR ? wr_view.delay : 4'h0);
                end
            end
            ST_DELAY:
            begin
                if (dly_ff == 16'h0000)
                    nxt_pwr = ST_SLEEP;
                else
                    nxt_dly = dly_ff - 16'h0001;
            end
            ST_SLEEP:
            begin
                if (wake_evt || (INACT_SLEEP_EN && own_act))
                    nxt_pwr = ST_AWAKE;
            end
            default:
                nxt_pwr = ST_AWAKE;
        endcase
    end

    // Power state and entry delay counter.
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pwr_ff <= ST_AWAKE;
            dly_ff <= 16'h0000;
        end
        else
        begin
            pwr_ff <= nxt_pwr;
            dly_ff <= nxt_dly;
        end
    end
    // State leaves on a flop so a reader never sees a decode glitch.
    assign PWR_STATE = pwr_ff;

    // ********************************************************
    // Beacon and carrier sense
    // ********************************************************
    pcse_cycle u_cycle (
        .clk         (CORE_CLK),
        .rst_n       (RESET_N),
        .run         (run),
        .crs         (crs_ff),
        .to_timer    (plca_ff.to_timer),
        .node_count  (plca_ff.node_count),
        .cycle_start (cycle_start),
        .cur_opp     (cur_opp)
    );

    // The filter count saturates so that a long frame cannot wrap it.
    assign flt_full   = (flt_ff == `PCSE_NOISE_CYC);
    assign nxt_flt    = !RX_ACTIVITY ? 4'h0 :
                        (flt_full ? flt_ff : flt_ff + 4'h1);
    // A beacon needs the engine running, so clearing PLCA enable stops new ones, but one decided
    // in the write cycle still goes out next cycle, inside the entry delay if sleep entry lands then too.
    assign nxt_beacon = cycle_start && is_coord && run;

    // Filtering delays carrier by a few cycles, at a cost in timer margin.
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            flt_ff    <= 4'h0;
            crs_ff    <= 1'b0;
            beacon_ff <= 1'b0;
        end
        else
        begin
            flt_ff    <= nxt_flt;
            crs_ff    <= flt_full && RX_ACTIVITY;
            beacon_ff <= nxt_beacon;
        end
    end
    assign BEACON    = beacon_ff;
    assign CRS       = crs_ff;
    // Transmitter stays on through sleep until supply is lost.
    assign TX_ENABLE = ANALOG_SUPPLY_OK;
endmodule
`default_nettype wire

// *** sim/pcse_checker.sv ***
// Port-level assertions for the coordinator sleep entry block.
// Assumes it is bound into pcse_top and sees only its ports.
`default_nettype none
module pcse_checker
(
    input wire logic                  CORE_CLK,
    input wire logic                  RESET_N,
    input wire logic                  SLEEP_WR,
    input wire logic [15:0]           SLEEP_WDATA,
    input wire pcse_pkg::pcse_sleep_s SLEEP_RDATA,
    input wire logic                  PLCA_WR,
    input wire logic                  PLCA_EN_IN,
    input wire logic [7:0]            NODE_IN,
    input wire logic                  TO_WR,
    input wire logic [7:0]            TO_IN,
    input wire logic [7:0]            TO_OUT,
    input wire logic                  TO_BELOW_MIN,
    input wire logic                  INACT_SLEEP_EN,
    input wire logic                  ANALOG_SUPPLY_OK,
    input wire logic                  RX_ACTIVITY,
    input wire logic                  BEACON,
    input wire logic                  TX_ENABLE,
    input wire logic                  CRS,
    input wire pcse_pkg::pcse_pwr_e   PWR_STATE
);
    timeunit 1ns;
    timeprecision 100ps;
    import pcse_pkg::*;
    // ********************************************
    // Shadow of the PLCA settings and assertions
    // ********************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    logic en_ff;
    logic coord_ff;
    // Requiring the shadow for two cycles lets beacon checks skip the cycle after the write.
    always_ff @(posedge CORE_CLK or negedge RESET_N)
        if (!RESET_N)
        begin
            en_ff <= 1'b0;
            coord_ff <= 1'b0;
        end
        else if (PLCA_WR)
        begin
            en_ff <= PLCA_EN_IN;
            coord_ff <= (NODE_IN == 8'h00);
        end
    a_rd_cal_one: assert property (SLEEP_WR |=>
        SLEEP_RDATA == {$past(SLEEP_WDATA[10:4]), 4'h1}) else $error("rd");
    a_to_load: assert property (TO_WR |=> TO_OUT == $past(TO_IN))
        else $error("to load");
    a_to_flag: assert property (TO_BELOW_MIN == (TO_OUT < 8'h1d))
        else $error("to flag");
    a_tx_supply: assert property (TX_ENABLE == ANALOG_SUPPLY_OK)
        else $error("tx enable");
    a_no_beacon_off: assert property (!en_ff [*2] |-> !BEACON)
        else $error("beacon off");
    a_coord_only: assert property (!coord_ff [*2] |-> !BEACON)
        else $error("beacon follower");
    a_beacon_pulse: assert property (BEACON |=> !BEACON)
        else $error("beacon width");
    a_sleep_entry: assert property (SLEEP_WR && SLEEP_WDATA[4] &&
        PWR_STATE == ST_AWAKE |=> PWR_STATE == ST_DELAY) else $error("ent");
    a_crs_filter: assert property (RX_ACTIVITY [*8] |-> CRS)
        else $error("crs");
    a_inact_wake: assert property (BEACON && INACT_SLEEP_EN &&
        PWR_STATE == ST_SLEEP |-> ##[0:8] PWR_STATE == ST_AWAKE)
        else $error("wake");
endmodule
`default_nettype wire

// *** sim/pcse_seg_model.sv ***
// Other nodes on the mixing segment, as seen by the receiver.
// Assumes go is a one-cycle pulse that starts a frame of len cycles.
`default_nettype none
module pcse_seg_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            rx
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************************************
    // Frame generator
    // ********************************************
    logic [7:0] cnt_ff;
    // Activity is a level that idles low between frames.
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            cnt_ff <= 8'h00;
        else if (go)
            cnt_ff <= len;
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    assign rx = (cnt_ff != 8'h00);
endmodule
`default_nettype wire

// *** sim/pcse_top_tb.sv ***
// Self-checking bench for the coordinator sleep entry block.
// Assumes the design, checker and segment model are compiled first.
`default_nettype none
module pcse_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pcse_pkg::*;
    // ********************************************
    // Stimulus, scoreboard and verdict
    // ********************************************
    logic        clk, rst_n, swr, pwr, pen, twr, ise, ito, sup, go, wkp;
    logic        tbm, bcn, txe, crs, rx, swr_d, twr_d;
    logic [15:0] swd;
    logic [7:0]  node, tin, tout;
    logic [15:0] q_rd[$];
    logic [7:0]  q_to[$];
    pcse_sleep_s srd, s;
    pcse_pwr_e   pst;
    int          n_fail = 0, n_checks = 0, nb = 0;
    pcse_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .SLEEP_WR(swr),
        .SLEEP_WDATA(swd), .SLEEP_RDATA(srd), .PLCA_WR(pwr),
        .PLCA_EN_IN(pen), .NODE_IN(node), .NODE_COUNT_IN(8'h02),
        .TO_WR(twr), .TO_IN(tin), .TO_OUT(tout), .TO_BELOW_MIN(tbm),
        .INACT_SLEEP_EN(ise), .INACT_TIMEOUT(ito), .ANALOG_SUPPLY_OK(sup),
        .WAKE_PIN(wkp), .RX_ACTIVITY(rx), .BEACON(bcn), .TX_ENABLE(txe),
        .CRS(crs), .PWR_STATE(pst));
    pcse_seg_model seg (.clk(clk), .rst_n(rst_n), .go(go), .len(8'h0c),
        .rx(rx));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Each strobe is one cycle, then one idle edge before the next.
    task automatic wr_sleep(input pcse_sleep_s v);
        swd <= {5'h00, v};
        swr <= 1'b1;
        v.cal = 4'h1;
        q_rd.push_back({5'h00, v});
        @(posedge clk);
        swr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr_to(input logic [7:0] v);
        tin <= v;
        twr <= 1'b1;
        q_to.push_back(v);
        @(posedge clk);
        twr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr_plca(input logic e, input logic [7:0] n);
        pen <= e;
        node <= n;
        pwr <= 1'b1;
        @(posedge clk);
        pwr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_st(input pcse_pwr_e st, input int lim);
        for (int i = 0; i < lim && pst !== st; i++)
            @(posedge clk);
        chk(16'(pst), 16'(st));
    endtask
    always @(posedge clk)
        {swr_d, twr_d} <= {swr, twr};
    // Results land one edge after their strobe; compare in order.
    always @(negedge clk)
    begin
        if (bcn === 1'b1)
            nb++;
        if (rst_n === 1'b1 && swr_d === 1'b1)
            chk(16'(srd), q_rd.pop_front());
        if (rst_n === 1'b1 && twr_d === 1'b1)
            chk(16'(tout), 16'(q_to.pop_front()));
    end
    initial
    begin
        repeat (8000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        {swr, pwr, pen, twr, ise, ito, go, wkp, swd, node, tin} = '0;
        {sup, rst_n} = 2'b10;
        void'($urandom(23033));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(16'(tout), 16'h0020);
        wr_to(8'h1d);
        chk(16'(tbm), 16'h0000);
        wr_to(8'h1c);
        chk(16'(tbm), 16'h0001);
        repeat (4) wr_to(8'($urandom_range(255, 33)));
        wr_to(8'h20);
        repeat (6)
        begin
            s = 11'($urandom);
            s.sleep_en = 1'b0;
            s.cal = 4'h0;
            wr_sleep(s);
        end
        wr_plca(1'b1, 8'h01);
        nb = 0;
        repeat (600) @(posedge clk);
        chk(16'(nb), 16'h0000);
        wr_plca(1'b1, 8'h00);
        nb = 0;
        repeat (600) @(posedge clk);
        chk(16'(nb > 1), 16'h0001);
        ise <= 1'b1;
        ito <= 1'b1;
        wait_st(ST_SLEEP, 8);
        ito <= 1'b0;
        wait_st(ST_AWAKE, 600);
        ise <= 1'b0;
        wr_plca(1'b0, 8'h00);
        nb = 0;
        s = '0;
        s.sleep_en = 1'b1;
        s.pin_wake = 1'b1;
        s.delay = 4'h1;
        wr_sleep(s);
        chk(16'(pst), 16'(ST_DELAY));
        repeat (250) @(posedge clk);
        chk(16'(pst), 16'(ST_DELAY));
        wait_st(ST_SLEEP, 12);
        chk(16'(nb), 16'h0000);
        wr_plca(1'b1, 8'h00);
        nb = 0;
        repeat (600) @(posedge clk);
        chk(16'(nb > 1), 16'h0001);
        chk(16'(pst), 16'(ST_SLEEP));
        sup <= 1'b0;
        @(posedge clk);
        chk(16'(txe), 16'h0000);
        sup <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (10) @(posedge clk);
        chk(16'(crs), 16'h0001);
        wkp <= 1'b1;
        wait_st(ST_AWAKE, 4);
        chk(16'(srd.sleep_en), 16'h0000);
        summarize();
    end
endmodule
bind pcse_top pcse_checker u_chk (.CORE_CLK, .RESET_N, .SLEEP_WR,
    .SLEEP_WDATA, .SLEEP_RDATA, .PLCA_WR, .PLCA_EN_IN, .NODE_IN, .TO_WR,
    .TO_IN, .TO_OUT, .TO_BELOW_MIN, .INACT_SLEEP_EN, .ANALOG_SUPPLY_OK,
    .RX_ACTIVITY, .BEACON, .TX_ENABLE, .CRS, .PWR_STATE);
`default_nettype wire
